// File: rtl/cps_regs.svh
// Constants for the core pointer and status register group
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// Condition word field positions
`define CPS_SIGN_EXT_BIT 0
`define CPS_UNS_MUL_BIT 1
`define CPS_SATURATE_BIT 2
`define CPS_FRAC_SHIFT_BIT 3
`define CPS_INT_EN_BIT 4
`define CPS_RESERVED_BIT 5
`define CPS_XFER_ZERO_BIT 6
`define CPS_XFER_SIGN_BIT 7
`define CPS_PTR_CARRY_BIT 8
`define CPS_PTR_ZERO_BIT 9
`define CPS_OVERFLOW_BIT 10
`define CPS_SIGN_BIT 11
`define CPS_ZERO_BIT 12
`define CPS_CARRY_BIT 13
`define CPS_TEST_ONE_BIT 14
`define CPS_TEST_TWO_BIT 15
`define CPS_TAG_BIT 16

// Reset values, step sizes and the loop and stack register numbers
`define CPS_STAT_RESET 17'h00000
`define CPS_STACK_STEP 16'h0002
`define CPS_CHAIN_BASE 6'h02
`define CPS_LOOP_REG 3'h4
`define CPS_STACK_REG 3'h7

// Pointer modification field codes
`define CPS_APMOD_NONE 2'h0
`define CPS_APMOD_DEC 2'h1
`define CPS_APMOD_INC 2'h2
`define CPS_APMOD_STRING 2'h3

`endif

// File: rtl/cps_pkg.sv
// Types shared by the core pointer and status register group
package cps_pkg;

  // Kind of destination written by the current instruction
  typedef enum logic [1:0] {
    CPS_DEST_NONE,
    CPS_DEST_ACC,
    CPS_DEST_RX,
    CPS_DEST_XBUS
  } cps_dest_t;

  // Hardware loop sequencing
  typedef enum logic {
    CPS_LOOP_IDLE,
    CPS_LOOP_RUN
  } cps_loop_st_t;

endpackage

// File: rtl/cps_rx_bank.sv
// Small register bank for the plain address registers
`timescale 1ns/1ns
module cps_rx_bank #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read port, data one cycle later
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // Storage words
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write, cleared on reset so reads never show unknowns
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce_in && wr_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

// File: rtl/cps_core_regs.sv
// Accumulator pointers, address registers, chain length and condition word
`timescale 1ns/1ns
`include "cps_regs.svh"
module cps_core_regs #(
  parameter int AP_W = 5,
  parameter int RX_W = 16,
  parameter int STAT_W = 17
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Accumulator pointer access
  input wire logic [1:0] ap_sel_in,
  input wire logic [1:0] ap_mod_in,
  input wire logic ap_wr_in,
  input wire logic [AP_W-1:0] ap_wr_data_in,
  output logic [AP_W-1:0] acc_idx_out,
  output logic [AP_W-1:0] acc_ofs_idx_out,
  // Address register access
  input wire logic rx_wr_in,
  input wire logic [2:0] rx_wr_sel_in,
  input wire logic [RX_W-1:0] rx_wr_data_in,
  input wire logic [2:0] rx_rd_sel_in,
  output logic [RX_W-1:0] rx_rd_data_out,
  // Hardware loop and subroutine events
  input wire logic loop_open_in,
  input wire logic loop_close_in,
  input wire logic call_in,
  input wire logic ret_in,
  output logic loop_again_out,
  output logic loop_active_out,
  output logic [RX_W-1:0] stack_ptr_out,
  // Chain length
  input wire logic chain_wr_in,
  input wire logic [4:0] chain_wr_data_in,
  output logic [5:0] chain_words_out,
  // Condition and mode word
  input wire logic [4:0] mode_set_in,
  input wire logic [4:0] mode_clr_in,
  input wire logic stat_wr_in,
  input wire logic [STAT_W-1:0] stat_wr_data_in,
  input wire logic flag_upd_in,
  input wire cps_pkg::cps_dest_t dest_kind_in,
  input wire logic [RX_W-1:0] res_value_in,
  input wire logic res_carry_in,
  input wire logic res_ovf_in,
  input wire logic [1:0] test_wr_in,
  input wire logic [1:0] test_val_in,
  input wire logic mem_rd_in,
  input wire logic mem_tag_in,
  output logic [STAT_W-1:0] stat_out,
  // Maskable interrupt gate
  input wire logic int_req_in,
  output logic int_req_out
);
  import cps_pkg::*;

  // Four accumulator pointers
  logic [AP_W-1:0] ap_q [4];
  // Selected pointer after pre-modification
  logic [AP_W-1:0] ap_next;
  // Loop counter and stack pointer kept outside the bank
  logic [RX_W-1:0] loop_cnt_q;
  logic [RX_W-1:0] stack_q;
  // Loop sequencer state
  cps_loop_st_t loop_st_q;
  // Chain length field
  logic [4:0] chain_len_q;
  // Condition word
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  // Bank read data and read path selection
  logic [RX_W-1:0] bank_rd;
  logic [RX_W-1:0] spec_rd_q;
  logic spec_sel_q;
  // Result is zero
  logic res_zero;

  assign res_zero = (res_value_in == 16'h0000);

  // Pointer step, wrapping inside five bits
  always_comb begin
    ap_next = ap_q[ap_sel_in];
    case (ap_mod_in)
      `CPS_APMOD_INC: ap_next = ap_q[ap_sel_in] + 5'h01;
      `CPS_APMOD_DEC: ap_next = ap_q[ap_sel_in] - 5'h01;
      default: ap_next = ap_q[ap_sel_in];
    endcase
  end

  // Pointer storage; step beats a plain load of the same pointer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        ap_q[i] <= 5'h00;
      end
    end else if (ce_in) begin
      if (ap_mod_in == `CPS_APMOD_INC || ap_mod_in == `CPS_APMOD_DEC) begin
        ap_q[ap_sel_in] <= ap_next;
      end else if (ap_wr_in) begin
        ap_q[ap_sel_in] <= ap_wr_data_in;
      end
    end
  end

  // Index handed to the accumulator file, already stepped
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acc_idx_out <= 5'h00;
      acc_ofs_idx_out <= 5'h10;
    end else if (ce_in) begin
      acc_idx_out <= ap_next;
      acc_ofs_idx_out <= ap_next ^ 5'h10;
    end
  end

  // Plain registers live in the bank; loop and stack slots unused there
  cps_rx_bank #(
    .WIDTH(RX_W),
    .DEPTH(8),
    .AW(3)
  ) u_bank (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wr_in(rx_wr_in),
    .wr_addr_in(rx_wr_sel_in),
    .wr_data_in(rx_wr_data_in),
    .rd_addr_in(rx_rd_sel_in),
    .rd_data_out(bank_rd)
  );

  // Capture loop or stack value alongside the bank read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      spec_rd_q <= 16'h0000;
      spec_sel_q <= 1'b0;
    end else if (ce_in) begin
      spec_sel_q <= (rx_rd_sel_in == `CPS_LOOP_REG) || (rx_rd_sel_in == `CPS_STACK_REG);
      spec_rd_q <= (rx_rd_sel_in == `CPS_LOOP_REG) ? loop_cnt_q : stack_q;
    end
  end

  // Both sources are registered, so the mux adds no extra delay
  assign rx_rd_data_out = spec_sel_q ? spec_rd_q : bank_rd;

  // Loop counter: close of block counts down, load from software
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      loop_cnt_q <= 16'h0000;
    end else if (ce_in) begin
      if (loop_close_in && loop_st_q == CPS_LOOP_RUN && !loop_cnt_q[15]) begin
        loop_cnt_q <= loop_cnt_q - 16'h0001;
      end else if (rx_wr_in && rx_wr_sel_in == `CPS_LOOP_REG) begin
        loop_cnt_q <= rx_wr_data_in;
      end
    end
  end

  // Loop sequencer: repeat while the count was not yet negative
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      loop_st_q <= CPS_LOOP_IDLE;
      loop_again_out <= 1'b0;
    end else if (ce_in) begin
      loop_again_out <= 1'b0;
      case (loop_st_q)
        CPS_LOOP_IDLE: begin
          if (loop_open_in) begin
            loop_st_q <= CPS_LOOP_RUN;
          end
        end
        CPS_LOOP_RUN: begin
          if (loop_close_in) begin
            if (loop_cnt_q[15]) begin
              loop_st_q <= CPS_LOOP_IDLE;
            end else begin
              loop_again_out <= 1'b1;
            end
          end
        end
        default: loop_st_q <= CPS_LOOP_IDLE;
      endcase
    end
  end

  assign loop_active_out = (loop_st_q == CPS_LOOP_RUN);

  // Stack pointer; call and return beat a software load
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stack_q <= 16'h0000;
    end else if (ce_in) begin
      if (call_in && !ret_in) begin
        stack_q <= stack_q + `CPS_STACK_STEP;
      end else if (ret_in && !call_in) begin
        stack_q <= stack_q - `CPS_STACK_STEP;
      end else if (!call_in && rx_wr_in && rx_wr_sel_in == `CPS_STACK_REG) begin
        // Borrowing it is safe only when software follows the save rule
        stack_q <= rx_wr_data_in;
      end
    end
  end

  assign stack_ptr_out = stack_q;

  // Chain length; only an explicit load changes it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chain_len_q <= 5'h00;
    end else if (ce_in && chain_wr_in) begin
      chain_len_q <= chain_wr_data_in;
    end
  end

  // Word count; values above 30 are illegal and not guarded
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chain_words_out <= `CPS_CHAIN_BASE;
    end else if (ce_in) begin
      chain_words_out <= {1'b0, chain_len_q} + `CPS_CHAIN_BASE;
    end
  end

  // Condition word next value: software first, hardware events override
  always_comb begin
    stat_d = stat_q;
    if (stat_wr_in) begin
      stat_d = stat_wr_data_in;
    end
    // Mode bits: set wins if both asked in one cycle
    stat_d[4:0] = (stat_d[4:0] & ~mode_clr_in) | mode_set_in;
    if (flag_upd_in) begin
      case (dest_kind_in)
        CPS_DEST_ACC: begin
          stat_d[`CPS_SIGN_BIT] = res_value_in[15];
          stat_d[`CPS_ZERO_BIT] = res_zero;
          stat_d[`CPS_CARRY_BIT] = res_carry_in;
          stat_d[`CPS_OVERFLOW_BIT] = res_ovf_in;
        end
        CPS_DEST_RX: begin
          stat_d[`CPS_PTR_CARRY_BIT] = res_carry_in;
          stat_d[`CPS_PTR_ZERO_BIT] = res_zero;
        end
        CPS_DEST_XBUS: begin
          stat_d[`CPS_XFER_SIGN_BIT] = res_value_in[15];
          stat_d[`CPS_XFER_ZERO_BIT] = res_zero;
        end
        default: stat_d = stat_d;
      endcase
    end
    // Test flags written by flag instructions
    if (test_wr_in[0]) begin
      stat_d[`CPS_TEST_ONE_BIT] = test_val_in[0];
    end
    if (test_wr_in[1]) begin
      stat_d[`CPS_TEST_TWO_BIT] = test_val_in[1];
    end
    if (mem_rd_in) begin
      stat_d[`CPS_TAG_BIT] = mem_tag_in;
    end
    // Reserved position always reads zero
    stat_d[`CPS_RESERVED_BIT] = 1'b0;
  end

  // Condition word storage; clean value even if startup skips clearing
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_q <= `CPS_STAT_RESET;
    end else if (ce_in) begin
      stat_q <= stat_d;
    end
  end

  assign stat_out = stat_q;

  // Maskable interrupt request passes only when enabled
  assign int_req_out = int_req_in & stat_q[`CPS_INT_EN_BIT];

  // Step wraps inside five bits
  chk_ap_inc_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ap_mod_in == `CPS_APMOD_INC && ap_q[ap_sel_in] == 5'h1f
    |=> acc_idx_out == 5'h00)
    else $error("pointer increment did not wrap");

  // Index follows the stepped pointer
  chk_ap_pre_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ap_mod_in == `CPS_APMOD_DEC
    |=> acc_idx_out == $past(ap_q[ap_sel_in]) - 5'h01)
    else $error("pointer decrement not applied before use");

  // Call moves stack up by two
  chk_stack_call: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && call_in && !ret_in |=> stack_ptr_out == $past(stack_ptr_out) + 16'h0002)
    else $error("call did not add two to stack");

  // Return moves stack down by two
  chk_stack_ret: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ret_in && !call_in |=> stack_ptr_out == $past(stack_ptr_out) - 16'h0002)
    else $error("return did not subtract two from stack");

  // Non-negative count repeats the block
  chk_loop_repeat: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && loop_active_out && loop_close_in && !loop_cnt_q[15]
    |=> loop_again_out && loop_active_out)
    else $error("loop did not repeat");

  // Negative count ends the loop
  chk_loop_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && loop_active_out && loop_close_in && loop_cnt_q[15]
    |=> !loop_again_out && !loop_active_out)
    else $error("loop did not stop on negative count");

  // Word count tracks length plus two
  chk_chain_words: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && chain_wr_in ##1 ce_in |=> chain_words_out == $past(chain_wr_data_in, 2) + 6'h02)
    else $error("chain word count wrong");

  // Interrupt blocked while disabled
  chk_int_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !stat_out[`CPS_INT_EN_BIT] |-> !int_req_out)
    else $error("interrupt passed while disabled");

  // Accumulator flags follow the result
  chk_acc_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && flag_upd_in && dest_kind_in == CPS_DEST_ACC
    |=> stat_out[`CPS_SIGN_BIT] == $past(res_value_in[15])
        && stat_out[`CPS_ZERO_BIT] == ($past(res_value_in) == 16'h0000)
        && stat_out[`CPS_CARRY_BIT] == $past(res_carry_in))
    else $error("accumulator flags wrong");

  // Transfer flags follow the moved value, pointer flags untouched
  chk_xfer_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && flag_upd_in && dest_kind_in == CPS_DEST_XBUS && !stat_wr_in
    |=> stat_out[`CPS_XFER_SIGN_BIT] == $past(res_value_in[15])
        && $stable(stat_out[`CPS_PTR_ZERO_BIT]))
    else $error("transfer flags wrong");

  // Memory read loads the tag
  chk_tag_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && mem_rd_in |=> stat_out[`CPS_TAG_BIT] == $past(mem_tag_in))
    else $error("tag bit not loaded");

endmodule

// File: test/cps_exec_model.sv
// Execution-side model that runs hardware loop blocks
`timescale 1ns/1ns
module cps_exec_model (
  // Clock and loop status
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [3:0] body_len_in,
  input wire logic loop_active_in,
  // Loop commands and pass count
  output logic loop_open_out,
  output logic loop_close_out,
  output logic busy_out,
  output int passes_out
);
  // Idle until the bench starts a loop
  initial begin
    loop_open_out = 1'b0;
    loop_close_out = 1'b0;
    busy_out = 1'b0;
    passes_out = 0;
  end
  // One close per pass; a long body stalls the close like slow code
  always @(posedge start_in) begin
    busy_out = 1'b1;
    passes_out = 0;
    @(negedge clk_in) loop_open_out = 1'b1;
    @(negedge clk_in) loop_open_out = 1'b0;
    do begin
      repeat (body_len_in) @(negedge clk_in);
      passes_out++;
      loop_close_out = 1'b1;
      @(negedge clk_in) loop_close_out = 1'b0;
      @(negedge clk_in);
    end while (loop_active_in === 1'b1);
    busy_out = 1'b0;
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the pointer and status register group
`timescale 1ns/1ns
module tb;
  import cps_pkg::*;
  typedef struct packed {logic [3:0] k; logic [16:0] v;} cps_exp_t;
  logic clk_in, rst_n_in, ce_in, ap_wr_in, rx_wr_in, loop_open_in, loop_close_in;
  logic call_in, ret_in, chain_wr_in, stat_wr_in, flag_upd_in, res_carry_in, res_ovf_in;
  logic mem_rd_in, mem_tag_in, int_req_in, int_req_out, loop_again_out, loop_active_out;
  logic start, busy, z;
  logic [1:0] ap_sel_in, ap_mod_in, test_wr_in, test_val_in;
  logic [2:0] rx_wr_sel_in, rx_rd_sel_in;
  logic [3:0] body_len;
  logic [4:0] ap_wr_data_in, chain_wr_data_in, mode_set_in, mode_clr_in, p;
  logic [4:0] acc_idx_out, acc_ofs_idx_out;
  logic [5:0] chain_words_out;
  logic [15:0] rx_wr_data_in, res_value_in, rx_rd_data_out, stack_ptr_out;
  logic [15:0] rv [8];
  logic [16:0] stat_wr_data_in, stat_out, e;
  logic [31:0] seed, r;
  cps_dest_t dest_kind_in;
  cps_exp_t expq [$];
  cps_exp_t x;
  int passes, err_count, compares, cycles, agains;
  string nm [9] = '{"stat", "acc_idx", "acc_ofs", "rx_rd", "stack", "chain", "int_req", "passes",
    "again"};

  cps_core_regs i_cps_core_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .ap_sel_in(ap_sel_in), .ap_mod_in(ap_mod_in), .ap_wr_in(ap_wr_in),
    .ap_wr_data_in(ap_wr_data_in), .acc_idx_out(acc_idx_out),
    .acc_ofs_idx_out(acc_ofs_idx_out), .rx_wr_in(rx_wr_in), .rx_wr_sel_in(rx_wr_sel_in),
    .rx_wr_data_in(rx_wr_data_in), .rx_rd_sel_in(rx_rd_sel_in),
    .rx_rd_data_out(rx_rd_data_out), .loop_open_in(loop_open_in),
    .loop_close_in(loop_close_in), .call_in(call_in), .ret_in(ret_in),
    .loop_again_out(loop_again_out), .loop_active_out(loop_active_out),
    .stack_ptr_out(stack_ptr_out), .chain_wr_in(chain_wr_in),
    .chain_wr_data_in(chain_wr_data_in), .chain_words_out(chain_words_out),
    .mode_set_in(mode_set_in), .mode_clr_in(mode_clr_in), .stat_wr_in(stat_wr_in),
    .stat_wr_data_in(stat_wr_data_in), .flag_upd_in(flag_upd_in),
    .dest_kind_in(dest_kind_in), .res_value_in(res_value_in), .res_carry_in(res_carry_in),
    .res_ovf_in(res_ovf_in), .test_wr_in(test_wr_in), .test_val_in(test_val_in),
    .mem_rd_in(mem_rd_in), .mem_tag_in(mem_tag_in), .stat_out(stat_out),
    .int_req_in(int_req_in), .int_req_out(int_req_out));

  cps_exec_model i_cps_exec_model (.clk_in(clk_in), .start_in(start), .body_len_in(body_len),
    .loop_active_in(loop_active_out), .loop_open_out(loop_open_in),
    .loop_close_out(loop_close_in), .busy_out(busy), .passes_out(passes));

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Pseudo-random source, fixed start
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Output chosen by an expectation kind
  function automatic logic [16:0] obs(input logic [3:0] k);
    case (k)
      4'h0: return stat_out;
      4'h1: return {12'h000, acc_idx_out};
      4'h2: return {12'h000, acc_ofs_idx_out};
      4'h3: return {1'b0, rx_rd_data_out};
      4'h4: return {1'b0, stack_ptr_out};
      4'h5: return {11'h000, chain_words_out};
      4'h6: return {16'h0000, int_req_out};
      4'h8: return agains[16:0];
      default: return passes[16:0];
    endcase
  endfunction

  task automatic push(input logic [3:0] k, input logic [16:0] v);
    expq.push_back({k, v});
  endtask

  // Drop all one-cycle requests
  task automatic idle();
    {ap_mod_in, ap_wr_in, rx_wr_in, call_in, ret_in, chain_wr_in} = '0;
    {mode_set_in, mode_clr_in, stat_wr_in, flag_upd_in, test_wr_in, mem_rd_in} = '0;
    ce_in = 1'b1;
  endtask

  // Let the taking edge pass, then release requests at the falling edge
  task automatic cyc();
    @(posedge clk_in);
    @(negedge clk_in);
    idle();
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Checker: every queued note, oldest first, against the settled outputs
  always @(negedge clk_in) begin
    #5;
    while (expq.size() > 0) begin
      x = expq.pop_front();
      compares++;
      if (obs(x.k) !== x.v) begin
        err_count++;
        $display("Error %s expected %h seen %h", nm[x.k], x.v, obs(x.k));
      end
    end
  end

  // Hang guard, well above the run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // Branch-back pulses stand one cycle, so each falling edge sees one once
  always @(negedge clk_in) begin
    if (loop_again_out === 1'b1) agains++;
  end

  initial begin
    seed = 32'hfbb9;
    {rst_n_in, start, body_len, ap_sel_in, ap_wr_data_in, rx_wr_sel_in, rx_rd_sel_in} = '0;
    {rx_wr_data_in, chain_wr_data_in, stat_wr_data_in, res_value_in} = '0;
    {res_carry_in, res_ovf_in, test_val_in, mem_tag_in} = '0;
    dest_kind_in = CPS_DEST_NONE;
    int_req_in = 1'b1;
    idle();
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    push(4'h0, 17'h00000);
    push(4'h2, 17'h00010);
    push(4'h5, 17'h00002);
    push(4'h6, 17'h00000);
    stat_wr_in = 1'b1;
    stat_wr_data_in = 17'h1ffff;
    cyc();
    push(4'h0, 17'h1ffdf);
    stat_wr_in = 1'b1;
    stat_wr_data_in = 17'h00000;
    cyc();
    e = 17'h00000;
    end_test("reset");
    // Pointers: load, then step across both wrap points
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      p = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : r[4:0];
      ap_sel_in = i[1:0];
      ap_wr_in = 1'b1;
      ap_wr_data_in = p;
      cyc();
      cyc();
      push(4'h1, {12'h000, p});
      for (int j = 0; j < 3; j++) begin
        ap_mod_in = (j == 0) ? 2'h2 : 2'h1;
        p = (j == 0) ? p + 5'h01 : p - 5'h01;
        cyc();
        push(4'h1, {12'h000, p});
        push(4'h2, {12'h000, p ^ 5'h10});
      end
    end
    end_test("pointers");
    // Address registers as plain storage
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      rv[i] = r[15:0];
      rx_wr_in = 1'b1;
      rx_wr_sel_in = i[2:0];
      rx_wr_data_in = rv[i];
      cyc();
    end
    for (int i = 0; i < 8; i++) begin
      rx_rd_sel_in = i[2:0];
      cyc();
      push(4'h3, {1'b0, rv[i]});
    end
    end_test("rx");
    // Stack loaded with interrupts masked, then call, return, both at once and a disabled cycle
    rx_wr_in = 1'b1;
    rx_wr_sel_in = 3'h7;
    rx_wr_data_in = 16'h0100;
    cyc();
    call_in = 1'b1;
    cyc();
    push(4'h4, 17'h00102);
    call_in = 1'b1;
    cyc();
    push(4'h4, 17'h00104);
    ret_in = 1'b1;
    cyc();
    push(4'h4, 17'h00102);
    {call_in, ret_in} = 2'b11;
    cyc();
    push(4'h4, 17'h00102);
    call_in = 1'b1;
    ce_in = 1'b0;
    cyc();
    push(4'h4, 17'h00102);
    end_test("stack");
    // Chain length, then a string step leaves it alone
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      chain_wr_data_in = (i == 0) ? 5'd0 : (i == 1) ? 5'd30 : 5'(r[7:0] % 31);
      chain_wr_in = 1'b1;
      cyc();
      cyc();
      push(4'h5, {11'h000, 6'(chain_wr_data_in) + 6'h02});
      ap_mod_in = 2'h3;
      cyc();
      cyc();
      push(4'h5, {11'h000, 6'(chain_wr_data_in) + 6'h02});
    end
    end_test("chain");
    // Hardware loops, fast and slow bodies
    for (int n = 0; n < 4; n += 3) begin
      rx_wr_in = 1'b1;
      rx_wr_sel_in = 3'h4;
      rx_wr_data_in = 16'(n);
      cyc();
      body_len = 4'(n + 1);
      agains = 0;
      start = 1'b1;
      cyc();
      start = 1'b0;
      while (busy === 1'b1) cyc();
      push(4'h7, 17'(n + 2));
      push(4'h8, 17'(n + 1));
    end
    end_test("loop");
    // Mode bits one by one, with the interrupt gate
    for (int i = 0; i < 5; i++) begin
      mode_set_in = 5'h01 << i;
      cyc();
      e[i] = 1'b1;
      push(4'h0, e);
      push(4'h6, {16'h0000, e[4]});
    end
    for (int i = 0; i < 5; i++) begin
      mode_clr_in = 5'h01 << i;
      cyc();
      e[i] = 1'b0;
      push(4'h0, e);
      push(4'h6, {16'h0000, e[4]});
    end
    end_test("modes");
    // Destination-selected flags, test flags and memory tag
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      flag_upd_in = 1'b1;
      dest_kind_in = cps_dest_t'(r[17:16]);
      res_value_in = (i < 8) ? 16'h0000 : r[15:0];
      res_carry_in = r[18];
      res_ovf_in = r[19];
      test_wr_in = r[21:20];
      test_val_in = r[23:22];
      mem_rd_in = r[24];
      mem_tag_in = r[25];
      z = (res_value_in == 16'h0000);
      if (r[17:16] == 2'h1) e[13:10] = {res_carry_in, z, res_value_in[15], res_ovf_in};
      if (r[17:16] == 2'h2) e[9:8] = {z, res_carry_in};
      if (r[17:16] == 2'h3) e[7:6] = {res_value_in[15], z};
      if (r[20]) e[14] = r[22];
      if (r[21]) e[15] = r[23];
      if (r[24]) e[16] = r[25];
      cyc();
      push(4'h0, e);
    end
    end_test("flags");
    // Reset in mid-run brings every register back to its start value
    rst_n_in = 1'b0;
    cyc();
    rst_n_in = 1'b1;
    push(4'h0, 17'h00000);
    push(4'h1, 17'h00000);
    push(4'h2, 17'h00010);
    push(4'h3, 17'h00000);
    push(4'h4, 17'h00000);
    push(4'h5, 17'h00002);
    end_test("reset again");
    cyc();
    finish_test();
  end
endmodule
